//--- design/rcms_pkg.sv
// package: constants, states and mode record of the reset sequencer
`default_nettype none
package rcms_pkg;

  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_WAIT   = 4'h2,
    ST_RESET  = 4'h4,
    ST_CONFIG = 4'h8
  } rcms_state_t;

  typedef struct packed {
    logic       bootByte;
    logic       csArb;
    logic       csFc;
    logic [4:0] csAddr;
    logic       parallel_port_e;
    logic       parallel_port_f;
    logic       testSlave;
    logic       clkCrystal;
    logic       bkptBdm;
  } rcms_cfg_t;

  // all pins high: default configuration
  localparam rcms_cfg_t CFG_RST = rcms_cfg_t'(13'h0000);

  // mode-select data line positions
  localparam int DL_BOOT  = 0;
  localparam int DL_ARB   = 1;
  localparam int DL_FC    = 2;
  localparam int DL_ADDR0 = 3;
  localparam int DL_PARALLEL_PORT_E = 8;
  localparam int DL_PARALLEL_PORT_F = 9;
  localparam int DL_TEST  = 11;

  localparam logic [7:0] FIRST_BUS_CYC = 8'h0A;
  localparam logic [7:0] RESET_HOLD_CYC = 8'h10;
  localparam logic [7:0] BUS_MON_CYC   = 8'h40;
  localparam logic [7:0] CNT_ZERO      = 8'h00;
  localparam logic [7:0] CNT_ONE       = 8'h01;

endpackage : rcms_pkg
`default_nettype wire

//--- design/rcms_mode_if.sv
// interface: mode capture between the sequencer and the mode latch
`default_nettype none
interface rcms_mode_if;
  import rcms_pkg::*;
  logic            capture;
  logic [11:0]     dataLines;
  logic            clkSelPin;
  logic            bkptPin;
  rcms_cfg_t       cfg;

  modport ctrl  (output capture, dataLines, clkSelPin, bkptPin,
                 input cfg);
  modport latch (input capture, dataLines, clkSelPin, bkptPin,
                 output cfg);
endinterface : rcms_mode_if
`default_nettype wire

//--- design/rcms_mode_latch.sv
// mode latch: decodes and holds the configuration sampled at release
`default_nettype none
module rcms_mode_latch
  import rcms_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   rst_n,
  rcms_mode_if.latch  modeBus
);

  rcms_cfg_t cfgQ;
  rcms_cfg_t cfgD;

  // a low line on 3..7 converts its chip select and all below, down to 6
  function automatic logic [4:0] addrMask(input logic [4:0] lines);
    logic [4:0] m;
    m    = 5'h00;
    m[4] = ~lines[4];
    for (int i = 3; i >= 0; i--)
    begin
      m[i] = ~lines[i] | m[i+1];
    end
    return m;
  endfunction : addrMask

  always_comb
  begin
    cfgD = cfgQ;
    if (modeBus.capture)
    begin
      cfgD.bootByte   = ~modeBus.dataLines[DL_BOOT];
      cfgD.csArb      = ~modeBus.dataLines[DL_ARB];
      cfgD.csFc       = ~modeBus.dataLines[DL_FC];
      cfgD.csAddr     = addrMask(modeBus.dataLines[DL_ADDR0+:5]);
      cfgD.parallel_port_e      = ~modeBus.dataLines[DL_PARALLEL_PORT_E];
      cfgD.parallel_port_f      = ~modeBus.dataLines[DL_PARALLEL_PORT_F];
      cfgD.testSlave  = ~modeBus.dataLines[DL_TEST];
      cfgD.clkCrystal = ~modeBus.clkSelPin;
      cfgD.bkptBdm    = ~modeBus.bkptPin;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cfgQ <= CFG_RST;
    else
      cfgQ <= cfgD;
  end

  assign modeBus.cfg = cfgQ;

  ////////////////////////////////////////////////////////////////////////
  property p_boot_width;
    @(posedge clock) disable iff (!rst_n)
      modeBus.capture |=> (cfgQ.bootByte == ~$past(modeBus.dataLines[0]));
  endproperty
  a_boot_width: assert property (p_boot_width)
    else $error("boot width not taken from line zero");

  property p_clk_breakpoint_pin;
    @(posedge clock) disable iff (!rst_n)
      modeBus.capture |=> (cfgQ.clkCrystal == ~$past(modeBus.clkSelPin))
                          && (cfgQ.bkptBdm == ~$past(modeBus.bkptPin));
  endproperty
  a_clk_breakpoint_pin: assert property (p_clk_breakpoint_pin)
    else $error("clock or breakpoint mode mis-sampled");

  property p_hold_cfg;
    @(posedge clock) disable iff (!rst_n)
      !modeBus.capture |=> $stable(cfgQ);
  endproperty
  a_hold_cfg: assert property (p_hold_cfg)
    else $error("configuration changed outside capture");

endmodule : rcms_mode_latch
`default_nettype wire

//--- design/rcms_top.sv
// reset sequencer: classifies resets, drives reset lines, fixes mode
`default_nettype none
module rcms_top
  import rcms_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        resetPinN,
  input  wire logic        powerUpReq,
  input  wire logic        watchdogTimeout,
  input  wire logic        haltReset,
  input  wire logic        lossOfReference,
  input  wire logic        testModeReq,
  input  wire logic        resetInstr,
  input  wire logic        busCycleActive,
  input  wire logic        busCycleEnd,
  input  wire logic [11:0] modeDataLines,
  input  wire logic        clockSourceSelectPin,
  input  wire logic        breakpointPin,
  input  wire logic        busGrant,
  output logic             pinResetDrive,
  output logic             clockModuleReset,
  output logic             masterResetLine,
  output logic             instructionResetLine,
  output logic             resetException,
  output logic             busMonitorTerminate,
  output logic             dataPullupEnable,
  output logic             coreStart,
  output logic             firstBusCycleOk,
  output logic             bootPortByteWide,
  output logic             csToBusArbitration,
  output logic             csToFunctionCode,
  output logic [4:0]       csToAddrMask,
  output logic             pinsToPortE,
  output logic             pinsToPortF,
  output logic             testSlaveMode,
  output logic             clockFromCrystal,
  output logic             backgroundDebugMode,
  output logic             slaveRegisterAccess
);

  rcms_mode_if modeBus ();

  rcms_state_t stateQ, stateD;
  logic [7:0]  cntQ, cntD;
  logic        pinSyncAQ, pinSyncBQ;
  logic        kClkQ, kClkD, kMstQ, kMstD, kExtQ, kExtD, kSysQ, kSysD;
  logic        monQ, monD, startD;
  logic        capture;
  logic        syncFull, asyncFull, anySource;

  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser: with no clock edges, a held pin waits for the clock
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pinSyncAQ <= 1'b1;
      pinSyncBQ <= 1'b1;
    end
    else
    begin
      pinSyncAQ <= resetPinN;
      pinSyncBQ <= pinSyncAQ;
    end
  end

  assign syncFull  = ~pinSyncBQ | lossOfReference;
  assign asyncFull = powerUpReq | watchdogTimeout | haltReset;
  assign anySource = syncFull | asyncFull | testModeReq | resetInstr;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    stateD  = stateQ;
    cntD    = cntQ;
    kClkD   = kClkQ;
    kMstD   = kMstQ;
    kExtD   = kExtQ;
    kSysD   = kSysQ;
    monD    = 1'b0;
    startD  = 1'b0;
    capture = 1'b0;
    unique case (stateQ)
      ST_RUN:
      begin
        cntD = CNT_ZERO;
        if (asyncFull)
        begin
          stateD = ST_RESET;
          {kMstD, kClkD, kExtD, kSysD} = 4'hE;
        end
        else if (syncFull || testModeReq)
        begin
          stateD = ST_WAIT;
          {kMstD, kClkD, kExtD, kSysD} = {1'b1, syncFull, 2'h2};
        end
        else if (resetInstr)
        begin
          stateD = ST_RESET;
          {kMstD, kClkD, kExtD, kSysD} = 4'h3;
        end
      end
      ST_WAIT:
      begin
        cntD  = cntQ + CNT_ONE;
        kClkD = kClkQ | syncFull;
        if (asyncFull)
        begin
          stateD = ST_RESET;
          kClkD  = 1'b1;
          cntD   = CNT_ZERO;
        end
        // a write in progress finishes before the lines assert
        else if (busCycleEnd || !busCycleActive)
        begin
          stateD = ST_RESET;
          cntD   = CNT_ZERO;
        end
        else if (cntQ == BUS_MON_CYC - CNT_ONE)
        begin
          monD   = 1'b1;
          stateD = ST_RESET;
          cntD   = CNT_ZERO;
        end
      end
      ST_RESET:
      begin
        kMstD = kMstQ | syncFull | asyncFull | testModeReq;
        kClkD = kClkQ | syncFull | asyncFull;
        kExtD = 1'b1;
        kSysD = kSysQ | resetInstr;
        if (anySource)
          cntD = CNT_ZERO;
        else if (cntQ == RESET_HOLD_CYC - CNT_ONE)
        begin
          stateD  = ST_CONFIG;
          capture = 1'b1;
          cntD    = CNT_ZERO;
        end
        else
          cntD = cntQ + CNT_ONE;
      end
      ST_CONFIG:
      begin
        cntD = cntQ + CNT_ONE;
        if (asyncFull)
        begin
          stateD = ST_RESET;
          {kMstD, kClkD, kExtD, kSysD} = 4'hE;
          cntD   = CNT_ZERO;
        end
        else if (cntQ == FIRST_BUS_CYC - CNT_ONE)
        begin
          stateD = ST_RUN;
          startD = 1'b1;
        end
      end
    endcase
  end

  // block reset counts as power-up: all full-reset lines asserted
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      stateQ <= ST_RESET;
      cntQ   <= CNT_ZERO;
      {kMstQ, kClkQ, kExtQ, kSysQ} <= 4'hE;
      monQ   <= 1'b0;
      {pinResetDrive, clockModuleReset, masterResetLine,
       instructionResetLine} <= 4'hE;
      {resetException, dataPullupEnable} <= 2'h3;
      {coreStart, firstBusCycleOk} <= 2'h0;
    end
    else
    begin
      stateQ <= stateD;
      cntQ   <= cntD;
      {kMstQ, kClkQ, kExtQ, kSysQ} <= {kMstD, kClkD, kExtD, kSysD};
      monQ   <= monD;
      pinResetDrive        <= (stateD == ST_RESET) & kExtD;
      clockModuleReset     <= (stateD == ST_RESET) & kClkD;
      masterResetLine      <= (stateD == ST_RESET) & kMstD;
      instructionResetLine <= (stateD == ST_RESET) & kSysD;
      resetException       <= (stateD != ST_RUN);
      dataPullupEnable     <= (stateD == ST_RESET);
      coreStart            <= startD;
      firstBusCycleOk      <= (stateD == ST_RUN);
    end
  end

  assign busMonitorTerminate = monQ;
  ////////////////////////////////////////////////////////////////////////
  assign modeBus.capture   = capture;
  assign modeBus.dataLines = modeDataLines;
  assign modeBus.clkSelPin = clockSourceSelectPin;
  assign modeBus.bkptPin   = breakpointPin;

  rcms_mode_latch u_latch (
    .clock   (clock),
    .rst_n   (rst_n),
    .modeBus (modeBus)
  );
  assign {bootPortByteWide, csToBusArbitration, csToFunctionCode,
          csToAddrMask, pinsToPortE, pinsToPortF, testSlaveMode,
          clockFromCrystal, backgroundDebugMode} = modeBus.cfg;
  assign slaveRegisterAccess = modeBus.cfg.testSlave & busGrant;

  ////////////////////////////////////////////////////////////////////////
  sequence s_release;
    capture ##1 !masterResetLine && !pinResetDrive;
  endsequence
  property p_first_bus;
    @(posedge clock) disable iff (!rst_n)
      s_release ##0 !asyncFull [*5] ##1 !asyncFull [*5]
        |=> firstBusCycleOk && coreStart;
  endproperty
  a_first_bus: assert property (p_first_bus)
    else $error("first bus cycle not ten cycles after release");
  property p_async_now;
    @(posedge clock) disable iff (!rst_n)
      (stateQ == ST_RUN) && asyncFull |=>
        masterResetLine && clockModuleReset && pinResetDrive;
  endproperty
  a_async_now: assert property (p_async_now)
    else $error("asynchronous reset not asserted at once");
  property p_instr_only;
    @(posedge clock) disable iff (!rst_n)
      (stateQ == ST_RUN) && resetInstr && !asyncFull && !syncFull
        && !testModeReq |=> pinResetDrive && instructionResetLine
        && !masterResetLine && !clockModuleReset;
  endproperty
  a_instr_only: assert property (p_instr_only)
    else $error("reset instruction drove wrong lines");
  property p_sync_wait;
    @(posedge clock) disable iff (!rst_n)
      (stateQ == ST_WAIT) && !asyncFull && busCycleActive && !busCycleEnd
        && (cntQ != BUS_MON_CYC - CNT_ONE) |=> !masterResetLine;
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("synchronous reset did not wait for bus cycle end");
  property p_test_lines;
    @(posedge clock) disable iff (!rst_n)
      (stateQ == ST_RUN) && testModeReq && !syncFull && !asyncFull
        ##1 !busCycleActive && !syncFull && !asyncFull
        |=> masterResetLine && pinResetDrive && !clockModuleReset;
  endproperty
  a_test_lines: assert property (p_test_lines)
    else $error("test reset drove clock module reset");
  property p_monitor;
    @(posedge clock) disable iff (!rst_n)
      $rose(busMonitorTerminate) |-> $past(stateQ == ST_WAIT)
        && masterResetLine;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("bus monitor fired outside synchronous reset");
  property p_exception;
    @(posedge clock) disable iff (!rst_n)
      (masterResetLine || instructionResetLine) |-> resetException
        && !firstBusCycleOk;
  endproperty
  a_exception: assert property (p_exception)
    else $error("core not held while reset lines asserted");
  property p_slave;
    @(posedge clock) disable iff (!rst_n)
      slaveRegisterAccess |-> testSlaveMode && busGrant;
  endproperty
  a_slave: assert property (p_slave)
    else $error("slave access without test mode and grant");
  property p_pullup;
    @(posedge clock) disable iff (!rst_n)
      $rose(coreStart) |-> !dataPullupEnable [*1];
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-ups still enabled at core start");

endmodule : rcms_top
`default_nettype wire

//--- tb/rcms_mode_drv.sv
// partner model: external mode-select conditioning on the pins
`default_nettype none
module rcms_mode_drv
(
  input  wire logic        holdReset,
  input  wire logic [11:0] pattern,
  input  wire logic        clkLevel,
  input  wire logic        bkptLevel,
  output logic [11:0]      dataLines,
  output logic             clkPin,
  output logic             bkptPin
);
  timeunit 1ns;
  timeprecision 1ps;
  // drives only while reset lines are up, long before the first bus
  // cycle; released data lines float to the weak pull-up
  assign dataLines = holdReset ? pattern : 12'hFFF;
  // no pull-up here, so a released pin shows the inverse level
  assign clkPin  = holdReset ? clkLevel : ~clkLevel;
  assign bkptPin = holdReset ? bkptLevel : ~bkptLevel;
endmodule : rcms_mode_drv
`default_nettype wire

//--- tb/testbench.sv
// testbench: reset sources, line timing and mode selection table
`default_nettype none
module testbench
  import rcms_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [11:0] data;
    logic        clkLvl;
    logic        bkptLvl;
    logic [2:0]  src;
    logic [12:0] exp;
  } rcms_row_t;
  // async sources by rotation; bus kept busy to prove no waiting
  localparam rcms_row_t ROWS [6] = '{
    '{12'hFFF, 1'h1, 1'h1, 3'h0, 13'h0000},
    '{12'hFFE, 1'h0, 1'h1, 3'h1, 13'h1002},
    '{12'hFFD, 1'h1, 1'h0, 3'h2, 13'h0801},
    '{12'hFF3, 1'h1, 1'h1, 3'h0, 13'h0420},
    '{12'hEDF, 1'h1, 1'h1, 3'h1, 13'h00F0},
    '{12'h577, 1'h0, 1'h0, 3'h2, 13'h03EF}
  };
  logic clock, rst_n, resetPinN, powerUpReq, watchdogTimeout, haltReset;
  logic lossOfReference, testModeReq, resetInstr, busCycleActive;
  logic busCycleEnd, clockSourceSelectPin, breakpointPin, busGrant;
  logic pinResetDrive, clockModuleReset, masterResetLine, coreStart;
  logic instructionResetLine, resetException, busMonitorTerminate;
  logic dataPullupEnable, firstBusCycleOk, bootPortByteWide;
  logic csToBusArbitration, csToFunctionCode, pinsToPortE, pinsToPortF;
  logic testSlaveMode, clockFromCrystal, backgroundDebugMode;
  logic slaveRegisterAccess, clkLevel, bkptLevel;
  logic [11:0] modeDataLines, pattern;
  logic [4:0]  csToAddrMask;
  logic [3:0]  resetLines;
  logic [12:0] cfgSeen;
  int numErrors = 0, nChecks = 0, cycles = 0, n;
  assign resetLines = {pinResetDrive, clockModuleReset, masterResetLine,
                       instructionResetLine};
  assign cfgSeen = {bootPortByteWide, csToBusArbitration, csToFunctionCode,
                    csToAddrMask, pinsToPortE, pinsToPortF, testSlaveMode,
                    clockFromCrystal, backgroundDebugMode};
  //////////////////////////////////////////////////////////////////////
  rcms_top dut (.clock, .rst_n, .resetPinN, .powerUpReq, .watchdogTimeout,
    .haltReset, .lossOfReference, .testModeReq, .resetInstr,
    .busCycleActive, .busCycleEnd, .modeDataLines, .clockSourceSelectPin,
    .breakpointPin, .busGrant, .pinResetDrive, .clockModuleReset,
    .masterResetLine, .instructionResetLine, .resetException,
    .busMonitorTerminate, .dataPullupEnable, .coreStart, .firstBusCycleOk,
    .bootPortByteWide, .csToBusArbitration, .csToFunctionCode,
    .csToAddrMask, .pinsToPortE, .pinsToPortF, .testSlaveMode,
    .clockFromCrystal, .backgroundDebugMode, .slaveRegisterAccess);
  rcms_mode_drv partner (.holdReset(pinResetDrive), .pattern, .clkLevel,
    .bkptLevel, .dataLines(modeDataLines), .clkPin(clockSourceSelectPin),
    .bkptPin(breakpointPin));
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      numErrors++;
      giveVerdict();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen,
               exp);
    end
  endtask : check
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : giveVerdict
  task automatic setSrc(input logic [2:0] k, input logic v);
    case (k)
      3'h0: powerUpReq <= v;
      3'h1: watchdogTimeout <= v;
      3'h2: haltReset <= v;
      3'h4: testModeReq <= v;
      default: resetInstr <= v;
    endcase
  endtask : setSrc
  // one-cycle source request, ends where its first answer is settled
  task automatic pulse(input logic [2:0] k);
    @(posedge clock) setSrc(k, 1'b1);
    @(posedge clock) setSrc(k, 1'b0);
    @(negedge clock);
  endtask : pulse
  task automatic waitStart();
    n = 0;
    while (coreStart !== 1'b1 && n < 80)
    begin
      @(negedge clock);
      n++;
    end
    check(16'(coreStart), 16'h1);
  endtask : waitStart
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    resetPinN = 1'b1;
    {powerUpReq, watchdogTimeout, haltReset, lossOfReference, testModeReq,
     resetInstr, busCycleActive, busCycleEnd, busGrant} = '0;
    pattern = 12'hFFF;
    {clkLevel, bkptLevel} = 2'b11;
    repeat (3) @(negedge clock);
    check(16'({resetLines, dataPullupEnable, coreStart}), 16'h3A);
    @(posedge clock) rst_n <= 1'b1;
    waitStart();
    check(16'(cfgSeen), 16'h0);
    $display("test reset done");
    foreach (ROWS[i])
    begin
      @(posedge clock);
      pattern <= ROWS[i].data;
      clkLevel <= ROWS[i].clkLvl;
      bkptLevel <= ROWS[i].bkptLvl;
      busCycleActive <= 1'b1;
      pulse(ROWS[i].src);
      check(16'(resetLines), 16'hE);
      check(16'(dataPullupEnable & resetException), 16'h1);
      n = 0;
      while (masterResetLine === 1'b1 && n < 40)
      begin
        @(negedge clock);
        n++;
      end
      check(16'(n), 16'(RESET_HOLD_CYC));
      n = 0;
      while (coreStart !== 1'b1 && n < 40)
      begin
        @(negedge clock);
        n++;
      end
      check(16'(n), 16'(FIRST_BUS_CYC));
      check(16'(cfgSeen), 16'(ROWS[i].exp));
      @(negedge clock);
      check(16'({coreStart, firstBusCycleOk}), 16'h1);
      $display("test row %0d done", i);
    end
    @(posedge clock) busGrant <= 1'b1;
    @(negedge clock) check(16'(slaveRegisterAccess), 16'h1);
    @(posedge clock) busGrant <= 1'b0;
    @(negedge clock) check(16'(slaveRegisterAccess), 16'h0);
    @(posedge clock);
    pattern <= 12'hFFF;
    resetPinN <= 1'b0;
    repeat (8) @(negedge clock);
    check(16'(resetLines), 16'h0);
    @(posedge clock) busCycleEnd <= 1'b1;
    @(posedge clock);
    busCycleEnd <= 1'b0;
    busCycleActive <= 1'b0;
    repeat (2) @(negedge clock);
    check(16'(resetLines), 16'hE);
    @(posedge clock) resetPinN <= 1'b1;
    waitStart();
    $display("test pin reset done");
    @(posedge clock);
    busCycleActive <= 1'b1;
    lossOfReference <= 1'b1;
    n = 0;
    while (busMonitorTerminate !== 1'b1 && n < 100)
    begin
      @(negedge clock);
      n++;
    end
    check(16'(resetLines), 16'hE);
    check(16'(n), 16'(BUS_MON_CYC) + 16'h0002);
    @(negedge clock) check(16'(busMonitorTerminate), 16'h0);
    @(posedge clock);
    lossOfReference <= 1'b0;
    busCycleActive <= 1'b0;
    waitStart();
    $display("test bus monitor done");
    pulse(3'h4);
    repeat (2) @(negedge clock);
    check(16'(resetLines), 16'hA);
    waitStart();
    pulse(3'h5);
    check(16'(resetLines), 16'h9);
    n = 0;
    while (resetLines !== 4'h0 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    check(16'(n), 16'(RESET_HOLD_CYC));
    waitStart();
    $display("test test and instruction done");
    @(posedge clock);
    powerUpReq <= 1'b1;
    resetInstr <= 1'b1;
    @(posedge clock);
    powerUpReq <= 1'b0;
    resetInstr <= 1'b0;
    @(negedge clock);
    check(16'(resetLines[3:1]), 16'h7);
    waitStart();
    $display("test priority done");
    giveVerdict();
  end
endmodule : testbench
`default_nettype wire
